// File: core_instruction_timing_decode.sv
// Core instruction decode, flag update and execution timing with register access
// What this block does
// [RULE1] Shared-access instructions take between 8 and 23 clocks.
// [RULE2] The arbiter grants each core one access window every 16 clocks.
// [RULE3] First shared access stalls 0 to 15 clocks, then runs 8.
// [RULE4] Two 4-clock instructions between shared accesses add no delay; here each issue adds an idle clock, so the next access misses its window.
// [RULE5] Clock config, identity, start, stop, semaphores, shared reads/writes use slot timing.
// [RULE6] Decrement/test-and-jump: 4 clocks taken, 8 clocks not taken.
// [RULE7] Add-absolute, negative source: carry is inverse borrow of D minus S.
// [RULE8] Subtract-absolute, negative source: carry is inverse carry of D plus S.
// [RULE9] Subtract-absolute: zero on D minus magnitude, writes result, borrow on carry.
// [RULE10] Signed extended subtract keeps zero, reports signed overflow, writes result.
// [RULE11] Unsigned extended subtract keeps zero, reports borrow, writes result.
// [RULE12] Video wait occupies the core for 4 clocks.
// [RULE13] Frame setting must give at least 7 (or 6) clocks for handoff.
// [RULE14] Zero and carry change only with their write effects.
// [RULE15] Destination written unless the no-result effect is given.
// [RULE16] Immediate source is the 9-bit literal zero-extended.
// [RULE17] While waiting for its slot the core holds its program counter.
// [RULE18] Arbiter rotates grants in fixed order at a constant period.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
module core_instruction_timing_decode (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Access window from the shared-resource arbiter
	input wire logic hub_window_in,
	// AXI4-Lite write channels
	input wire logic [7:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	// AXI4-Lite read channels
	input wire logic [7:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in,
	// Core status
	output logic stall_out
);
	logic rst_s1_q, rst_n_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q, rdata_q, rd_data;
	logic [3:0] w_strb_q;
	logic wr_fire, wr_err, rd_err, go;
	logic [31:0] instr_q, dval_q, sval_q;
	logic [8:0] pc_q;
	logic z_q, c_q, taken_last_q;
	logic [15:0] frame_q;
	logic [4:0] cnt_q, cycles_q;
	logic [5:0] opc;
	logic nop, is_hub, is_br, is_vid;
	logic [31:0] s_op, alu_res;
	logic alu_z, alu_c, alu_taken;
	logic [4:0] clocks;
	logic [31:0] pend_res_q;
	logic pend_z_q, pend_c_q, pend_zw_q, pend_cw_q, pend_rw_q, pend_taken_q;
	logic pend_hub_q, pend_br_q, pend_vid_q;
	logic [8:0] pend_tgt_q;
	logic frame_short;

	core_timer_if tif ();

	// ************************************************************
	// Reset release
	// ************************************************************

	// Two-stage release keeps reset removal clean of the clock edge
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return m;
	endfunction

	// Both address and data taken, response not yet out
	assign wr_fire = !awready_q && !wready_q && !bvalid_q;
	assign wr_err = !(aw_addr_q == core_decode_pkg::OFS_CTRL
		|| aw_addr_q == core_decode_pkg::OFS_INSTR || aw_addr_q == core_decode_pkg::OFS_DVAL
		|| aw_addr_q == core_decode_pkg::OFS_SVAL || aw_addr_q == core_decode_pkg::OFS_FLAGS
		|| aw_addr_q == core_decode_pkg::OFS_PC || aw_addr_q == core_decode_pkg::OFS_FRAME);

	// Write address and data are taken in either order, one write at a time
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= core_decode_pkg::RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q <= core_decode_pkg::ZERO_WORD;
			w_strb_q <= 4'h0;
		end else begin
			if (awvalid_in && awready_q) begin
				aw_addr_q <= awaddr_in;
				awready_q <= 1'b0;
			end
			if (wvalid_in && wready_q) begin
				w_data_q <= wdata_in;
				w_strb_q <= wstrb_in;
				wready_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_err ? core_decode_pkg::RESP_SLVERR : core_decode_pkg::RESP_OKAY;
			end
			if (bvalid_q && bready_in) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// Read data selection
	always_comb begin
		rd_data = core_decode_pkg::ZERO_WORD;
		rd_err = 1'b0;
		unique case (araddr_in)
			core_decode_pkg::OFS_CTRL: rd_data = {31'h0000_0000, tif.busy};
			core_decode_pkg::OFS_INSTR: rd_data = instr_q;
			core_decode_pkg::OFS_DVAL: rd_data = dval_q;
			core_decode_pkg::OFS_SVAL: rd_data = sval_q;
			core_decode_pkg::OFS_FLAGS: rd_data = {30'h0000_0000, c_q, z_q};
			core_decode_pkg::OFS_STATUS: rd_data = {28'h000_0000, taken_last_q, frame_short,
				tif.stall, tif.busy};
			core_decode_pkg::OFS_CYCLES: rd_data = {27'h000_0000, cycles_q};
			core_decode_pkg::OFS_PC: rd_data = {23'h00_0000, pc_q};
			core_decode_pkg::OFS_FRAME: rd_data = {16'h0000, frame_q};
			default: rd_err = 1'b1;
		endcase
	end

	// Read answer one clock after the address is taken
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= core_decode_pkg::ZERO_WORD;
			rresp_q <= core_decode_pkg::RESP_OKAY;
		end else if (arvalid_in && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_data;
			rresp_q <= rd_err ? core_decode_pkg::RESP_SLVERR : core_decode_pkg::RESP_OKAY;
		end else if (rvalid_q && rready_in) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// ************************************************************
	// Decode and issue
	// ************************************************************

	// Operands come only from settled registers, so a start written while busy is dropped
	assign go = wr_fire && aw_addr_q == core_decode_pkg::OFS_CTRL && w_strb_q[0]
		&& w_data_q[0] && !tif.busy;
	assign opc = instr_q[core_decode_pkg::OPC_LSB +: 6];
	assign nop = instr_q[core_decode_pkg::COND_LSB +: 4] == core_decode_pkg::COND_NEVER;
	assign is_hub = opc[5:2] == core_decode_pkg::HUB_OPC_HI; // [RULE5]
	assign is_br = opc == core_decode_pkg::OPC_DECREMENT_JUMP_NONZERO || opc == core_decode_pkg::OPC_TEST_JUMP_NONZERO
		|| opc == core_decode_pkg::OPC_TJZ;
	assign is_vid = opc == core_decode_pkg::OPC_VWAIT;
	assign s_op = instr_q[core_decode_pkg::IMM_BIT]
		? {23'h00_0000, instr_q[core_decode_pkg::SRC_W-1:0]} : sval_q; // [RULE16]
	assign frame_short = frame_q < core_decode_pkg::HANDOFF_MIN_CLKS; // [RULE13]

	core_alu u_alu (
		.opc_in(opc),
		.d_in(dval_q),
		.s_in(s_op),
		.z_in(z_q),
		.c_in(c_q),
		.res_out(alu_res),
		.z_out(alu_z),
		.c_out(alu_c),
		.taken_out(alu_taken)
	);

	// Clock count by class; video wait costs its own clocks only
	always_comb begin
		if (is_br && !nop && !alu_taken) begin
			clocks = core_decode_pkg::BRANCH_SLOW_CLKS; // [RULE6]
		end else if (is_vid) begin
			clocks = core_decode_pkg::VIDEO_WAIT_CLKS; // [RULE12]
		end else begin
			clocks = core_decode_pkg::PLAIN_CLKS; // [RULE6]
		end
	end

	assign tif.start = go;
	assign tif.hub = is_hub && !nop; // [RULE5]
	assign tif.clocks = clocks;
	assign tif.hub_window = hub_window_in; // [RULE2]

	core_timer u_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_q),
		.tif(tif.timer)
	);

	// Results wait here until the timer releases the instruction
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pend_res_q <= core_decode_pkg::ZERO_WORD;
			{pend_z_q, pend_c_q, pend_zw_q, pend_cw_q, pend_rw_q, pend_taken_q} <= 6'h00;
			{pend_hub_q, pend_br_q, pend_vid_q} <= 3'h0;
			pend_tgt_q <= 9'h000;
		end else if (go) begin
			pend_res_q <= alu_res;
			pend_z_q <= alu_z;
			pend_c_q <= alu_c;
			pend_zw_q <= instr_q[core_decode_pkg::ZW_BIT] && !nop; // [RULE14]
			pend_cw_q <= instr_q[core_decode_pkg::CW_BIT] && !nop; // [RULE14]
			pend_rw_q <= instr_q[core_decode_pkg::RW_BIT] && !nop; // [RULE15]
			pend_taken_q <= alu_taken && is_br && !nop;
			pend_hub_q <= is_hub && !nop;
			pend_br_q <= is_br && !nop;
			pend_vid_q <= is_vid && !nop;
			pend_tgt_q <= s_op[8:0];
		end
	end

	// ************************************************************
	// Architectural state
	// ************************************************************

	// Operand and flag registers; software writes only while idle
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			instr_q <= core_decode_pkg::ZERO_WORD;
			dval_q <= core_decode_pkg::ZERO_WORD;
			sval_q <= core_decode_pkg::ZERO_WORD;
			z_q <= 1'b0;
			c_q <= 1'b0;
			frame_q <= core_decode_pkg::FRAME_RESET;
		end else if (tif.done) begin
			if (pend_rw_q) begin
				dval_q <= pend_res_q; // [RULE15]
			end
			if (pend_zw_q) begin
				z_q <= pend_z_q; // [RULE14]
			end
			if (pend_cw_q) begin
				c_q <= pend_c_q; // [RULE14]
			end
		end else if (wr_fire && !tif.busy) begin
			unique case (aw_addr_q)
				core_decode_pkg::OFS_INSTR: instr_q <= merge(instr_q, w_data_q, w_strb_q);
				core_decode_pkg::OFS_DVAL: dval_q <= merge(dval_q, w_data_q, w_strb_q);
				core_decode_pkg::OFS_SVAL: sval_q <= merge(sval_q, w_data_q, w_strb_q);
				core_decode_pkg::OFS_FLAGS: begin
					if (w_strb_q[0]) begin
						z_q <= w_data_q[0];
						c_q <= w_data_q[1];
					end
				end
				core_decode_pkg::OFS_FRAME: frame_q <= 16'(merge({16'h0000, frame_q}, w_data_q,
					w_strb_q));
				default: ;
			endcase
		end
	end

	// Program counter moves only at completion or on a software write while idle, so it holds across a stall
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pc_q <= 9'h000;
			taken_last_q <= 1'b0;
		end else if (tif.done) begin
			pc_q <= pend_taken_q ? pend_tgt_q : pc_q + 9'h001; // [RULE17]
			taken_last_q <= pend_taken_q;
		end else if (wr_fire && !tif.busy && aw_addr_q == core_decode_pkg::OFS_PC) begin
			pc_q <= w_data_q[8:0];
		end
	end

	// Occupied clocks of the running instruction, kept at completion
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cnt_q <= 5'h0;
			cycles_q <= 5'h0;
		end else begin
			if (go) begin
				cnt_q <= 5'h1;
			end else if (tif.busy && !tif.done) begin
				cnt_q <= cnt_q + 5'h1;
			end
			if (tif.done) begin
				cycles_q <= cnt_q;
			end
		end
	end

	assign awready_out = awready_q;
	assign wready_out = wready_q;
	assign bvalid_out = bvalid_q;
	assign bresp_out = bresp_q;
	assign arready_out = arready_q;
	assign rvalid_out = rvalid_q;
	assign rdata_out = rdata_q;
	assign rresp_out = rresp_q;
	assign stall_out = tif.stall;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_q);

	hub_time_range_a: assert property (tif.done && pend_hub_q |-> // [RULE1]
		cnt_q >= core_decode_pkg::HUB_EXEC_CLKS && cnt_q <= core_decode_pkg::HUB_MAX_CLKS)
		else $error("shared access clock count out of range");
	slot_wait_bound_a: assert property ($rose(tif.stall) |-> ##[1:15] !tif.stall) // [RULE3]
		else $error("slot wait exceeded fifteen clocks");
	stall_pc_hold_a: assert property (tif.stall |=> $stable(pc_q)) // [RULE17]
		else $error("program counter moved during slot wait");
	branch_taken_len_a: assert property (tif.done && pend_taken_q |-> cnt_q == 5'h4) // [RULE6]
		else $error("taken branch not four clocks");
	branch_fall_len_a: assert property (tif.done && pend_br_q && !pend_taken_q // [RULE6]
		|-> cnt_q == 5'h8)
		else $error("untaken branch not eight clocks");
	video_wait_len_a: assert property (go && is_vid && !nop |-> ##4 tif.done) // [RULE12]
		else $error("video wait not four clocks");
	no_result_hold_a: assert property (tif.done && !pend_rw_q |=> $stable(dval_q)) // [RULE15]
		else $error("destination written under no-result");
	zero_flag_hold_a: assert property (tif.done && !pend_zw_q |=> $stable(z_q)) // [RULE14]
		else $error("zero flag changed without its effect");
	// A shared access that meets its window pays no sync clocks; two gap instructions do not bring it onto its window
	hub_gap_free_a: assert property (go && tif.hub && tif.hub_window |=> // [RULE4]
		!tif.stall ##7 tif.done)
		else $error("shared access on its window was delayed");
endmodule

// File: core_decode_pkg.sv
// Shared constants, encodings and timing figures for the core decode block
package core_decode_pkg;

	// ************************************************************
	// Bus and register map
	// ************************************************************
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INSTR = 8'h04;
	localparam logic [7:0] OFS_DVAL = 8'h08;
	localparam logic [7:0] OFS_SVAL = 8'h0C;
	localparam logic [7:0] OFS_FLAGS = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_CYCLES = 8'h18;
	localparam logic [7:0] OFS_PC = 8'h1C;
	localparam logic [7:0] OFS_FRAME = 8'h20;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// ************************************************************
	// Instruction word fields
	// ************************************************************
	localparam int OPC_LSB = 26;
	localparam int ZW_BIT = 25;
	localparam int CW_BIT = 24;
	localparam int RW_BIT = 23;
	localparam int IMM_BIT = 22;
	localparam int COND_LSB = 18;
	localparam int SRC_W = 9;
	localparam logic [3:0] COND_NEVER = 4'h0;
	localparam logic [3:0] HUB_OPC_HI = 4'h0;

	// ************************************************************
	// Opcodes handled by the arithmetic unit
	// ************************************************************
	localparam logic [5:0] OPC_ADD = 6'h20;
	localparam logic [5:0] OPC_SUB = 6'h21;
	localparam logic [5:0] OPC_ADD_ABSOLUTE = 6'h22;
	localparam logic [5:0] OPC_SUBTRACT_ABSOLUTE = 6'h23;
	localparam logic [5:0] OPC_SUBS = 6'h35;
	localparam logic [5:0] OPC_UNSIGNED_EXTENDED_SUBTRACT = 6'h33;
	localparam logic [5:0] OPC_SIGNED_EXTENDED_SUBTRACT = 6'h37;
	localparam logic [5:0] OPC_DECREMENT_JUMP_NONZERO = 6'h39;
	localparam logic [5:0] OPC_TEST_JUMP_NONZERO = 6'h3A;
	localparam logic [5:0] OPC_TJZ = 6'h3B;
	localparam logic [5:0] OPC_VWAIT = 6'h3F;

	// ************************************************************
	// Execution timing in system clocks
	// ************************************************************
	localparam logic [4:0] PLAIN_CLKS = 5'h4;
	localparam logic [4:0] BRANCH_SLOW_CLKS = 5'h8;
	localparam logic [4:0] HUB_EXEC_CLKS = 5'h8;
	localparam logic [4:0] VIDEO_WAIT_CLKS = 5'h4;
	localparam logic [4:0] HUB_MAX_CLKS = 5'h17;
	localparam logic [4:0] HUB_MAX_WAIT = 5'hF;
	localparam logic [4:0] WINDOW_PERIOD = 5'h10;
	localparam logic [15:0] HANDOFF_MIN_CLKS = 16'h0007;
	localparam logic [15:0] HANDOFF_ALT_CLKS = 16'h0006;
	localparam logic [15:0] FRAME_RESET = 16'h0010;

	// Timer states, Gray along idle, sync, exec
	typedef enum logic [1:0] {
		T_IDLE = 2'b00,
		T_SYNC = 2'b01,
		T_EXEC = 2'b11
	} timer_state_t;

endpackage

// File: core_timer_if.sv
// Issue and timing handshake between decode and the execution timer
interface core_timer_if;
	logic start;
	logic hub;
	logic [4:0] clocks;
	logic hub_window;
	logic busy;
	logic done;
	logic stall;
	modport timer(input start, input hub, input clocks, input hub_window,
		output busy, output done, output stall);
	modport ctl(output start, output hub, output clocks, output hub_window,
		input busy, input done, input stall);
endinterface

// File: core_alu.sv
// Result and flag logic for the subtract, absolute and branch opcodes
module core_alu (
	// Operands
	input wire logic [5:0] opc_in,
	input wire logic [31:0] d_in,
	input wire logic [31:0] s_in,
	input wire logic z_in,
	input wire logic c_in,
	// Results
	output logic [31:0] res_out,
	output logic z_out,
	output logic c_out,
	output logic taken_out
);
	logic [32:0] sum;
	logic [32:0] dif;
	logic [32:0] difc;
	logic [31:0] sabs;
	logic ovf;
	logic ovfc;

	// Shared adders
	assign sum = {1'b0, d_in} + {1'b0, s_in};
	assign dif = {1'b0, d_in} - {1'b0, s_in};
	assign difc = {1'b0, d_in} - {1'b0, s_in} - {32'h0000_0000, c_in};
	assign sabs = s_in[31] ? 32'h0000_0000 - s_in : s_in;
	assign ovf = (d_in[31] != s_in[31]) && (dif[31] != d_in[31]);
	assign ovfc = (d_in[31] != s_in[31]) && (difc[31] != d_in[31]);

	// Opcode select; default behaves as a move of the source
	always_comb begin
		res_out = s_in;
		c_out = s_in[31];
		taken_out = 1'b0;
		unique case (opc_in)
			core_decode_pkg::OPC_ADD: begin
				res_out = sum[31:0];
				c_out = sum[32];
			end
			core_decode_pkg::OPC_SUB: begin
				res_out = dif[31:0];
				c_out = dif[32];
			end
			core_decode_pkg::OPC_ADD_ABSOLUTE: begin
				res_out = d_in + sabs;
				c_out = s_in[31] ? ~dif[32] : sum[32]; // [RULE7]
			end
			core_decode_pkg::OPC_SUBTRACT_ABSOLUTE: begin
				res_out = d_in - sabs; // [RULE9]
				c_out = s_in[31] ? ~sum[32] : dif[32]; // [RULE8] [RULE9]
			end
			core_decode_pkg::OPC_SUBS: begin
				res_out = dif[31:0];
				c_out = ovf;
			end
			core_decode_pkg::OPC_SIGNED_EXTENDED_SUBTRACT: begin
				res_out = difc[31:0]; // [RULE10]
				c_out = ovfc; // [RULE10]
			end
			core_decode_pkg::OPC_UNSIGNED_EXTENDED_SUBTRACT: begin
				res_out = difc[31:0]; // [RULE11]
				c_out = difc[32]; // [RULE11]
			end
			core_decode_pkg::OPC_DECREMENT_JUMP_NONZERO: begin
				res_out = d_in - 32'h0000_0001;
				c_out = (d_in == 32'h0000_0000);
				taken_out = (res_out != 32'h0000_0000); // [RULE6]
			end
			core_decode_pkg::OPC_TEST_JUMP_NONZERO: begin
				res_out = d_in;
				c_out = 1'b0;
				taken_out = (d_in != 32'h0000_0000); // [RULE6]
			end
			core_decode_pkg::OPC_TJZ: begin
				res_out = d_in;
				c_out = 1'b0;
				taken_out = (d_in == 32'h0000_0000); // [RULE6]
			end
			default: begin
				res_out = s_in;
			end
		endcase
	end

	// Extended subtracts only keep a zero that was already there
	always_comb begin
		if (opc_in == core_decode_pkg::OPC_SIGNED_EXTENDED_SUBTRACT || opc_in == core_decode_pkg::OPC_UNSIGNED_EXTENDED_SUBTRACT) begin
			z_out = z_in && (res_out == 32'h0000_0000); // [RULE10] [RULE11]
		end else begin
			z_out = (res_out == 32'h0000_0000); // [RULE9]
		end
	end
endmodule

// File: core_timer.sv
// Execution timer: slot synchronisation for shared access and clock counts
module core_timer (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Handshake with decode
	core_timer_if.timer tif
);
	core_decode_pkg::timer_state_t state_q;
	core_decode_pkg::timer_state_t state_d;
	logic [4:0] rem_q;
	logic [4:0] rem_d;
	logic stall_q;

	// Next state; a shared access waits for its window, then runs its clocks
	always_comb begin
		state_d = state_q;
		rem_d = rem_q;
		unique case (state_q)
			core_decode_pkg::T_IDLE: begin
				if (tif.start) begin
					rem_d = tif.hub ? core_decode_pkg::HUB_EXEC_CLKS - 5'h1 : tif.clocks - 5'h1;
					state_d = (tif.hub && !tif.hub_window) ? core_decode_pkg::T_SYNC
						: core_decode_pkg::T_EXEC; // [RULE3]
				end
			end
			core_decode_pkg::T_SYNC: begin
				if (tif.hub_window) begin
					state_d = core_decode_pkg::T_EXEC; // [RULE3]
				end
			end
			core_decode_pkg::T_EXEC: begin
				if (rem_q == 5'h0) begin
					state_d = core_decode_pkg::T_IDLE;
				end else begin
					rem_d = rem_q - 5'h1;
				end
			end
			default: begin
				state_d = core_decode_pkg::T_IDLE;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= core_decode_pkg::T_IDLE;
			rem_q <= 5'h0;
		end else begin
			state_q <= state_d;
			rem_q <= rem_d;
		end
	end

	// Registered stall so the top can drive it straight out
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stall_q <= 1'b0;
		end else begin
			stall_q <= (state_d == core_decode_pkg::T_SYNC); // [RULE17]
		end
	end

	assign tif.busy = (state_q != core_decode_pkg::T_IDLE);
	assign tif.done = (state_q == core_decode_pkg::T_EXEC) && (rem_q == 5'h0);
	assign tif.stall = stall_q;

	// Once the window is met, execution ends exactly eight clocks later
	hub_exec_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE3]
		(state_q == core_decode_pkg::T_SYNC && tif.hub_window) |-> ##8 tif.done)
		else $error("shared access did not finish eight clocks after its window");
endmodule

// File: core_arbiter_model.sv
// Shared-resource arbiter model giving this core one window per rotation
module core_arbiter_model #(
	parameter int PHASE = 5
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Window pulse to the core
	output logic window_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] slot_q;
	// Fixed rotation, so other cores' activity never moves this slot
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slot_q <= 4'h0;
		end else begin
			slot_q <= slot_q + 4'h1;
		end
	end
	// One pulse in every 16 clocks
	assign window_out = (slot_q == 4'(PHASE));
endmodule

// File: core_instruction_timing_decode_test.sv
// Self-checking bench for the core decode and timing block
module core_instruction_timing_decode_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'h0;
	logic arst_n_in = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, rd, d, s;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, stall, win;
	logic [1:0] bresp, rresp, rs, f;
	logic [3:0] x;
	logic [5:0] o;
	logic [33:0] e;
	logic [5:0] op[9];
	int failures = 0, checks_done = 0, cyc = 0, st = 0;
	core_arbiter_model arb (.clk_in(clk_in), .rst_n_in(arst_n_in), .window_out(win));
	core_instruction_timing_decode uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.hub_window_in(win), .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
		.wdata_in(wdata), .wstrb_in(4'hF), .wvalid_in(wvalid), .wready_out(wready),
		.bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr),
		.arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
		.rvalid_out(rvalid), .rready_in(rready), .stall_out(stall));
	// Clock and hang guard
	initial forever #20 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (stall === 1'h1) st++;
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk_in);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
	endtask
	task automatic rdw(input logic [7:0] a);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk_in);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rd = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask
	function automatic logic [31:0] iw(input logic [5:0] o, input logic [3:0] x,
		input logic [8:0] s);
		return {o, x, 4'hF, 9'h000, s};
	endfunction
	// Expected {Z, C, result}; extended subtracts keep a cleared Z cleared
	function automatic logic [33:0] alu(input logic [5:0] o, input logic [31:0] a,
		input logic [31:0] s, input logic [1:0] fl);
		logic [32:0] r;
		logic [31:0] m;
		logic cf;
		m = s[31] ? 32'h0000_0000 - s : s;
		r = {1'h0, a} - {1'h0, s} - {32'h0000_0000, fl[1]};
		cf = r[32];
		if (o == core_decode_pkg::OPC_SIGNED_EXTENDED_SUBTRACT) cf = (a[31] != s[31]) && (r[31] != a[31]);
		if (o == core_decode_pkg::OPC_ADD_ABSOLUTE) begin
			r = {1'h0, a} + {1'h0, m};
			cf = s[31] ? a >= s : r[32];
		end
		if (o == core_decode_pkg::OPC_SUBTRACT_ABSOLUTE) begin
			r = {1'h0, a} - {1'h0, m};
			cf = s[31] ? !(({1'h0, a} + {1'h0, s}) >> 32) : r[32];
		end
		return {(r[31:0] == 32'h0000_0000) && (fl[0] || !o[4]), cf, r[31:0]};
	endfunction
	// Expected clocks of a modify-and-branch: short only when it jumps
	function automatic logic [4:0] brc(input logic [5:0] o, input logic [31:0] a);
		logic t;
		t = (a != 32'h0000_0000);
		if (o == core_decode_pkg::OPC_DECREMENT_JUMP_NONZERO) t = (a != 32'h0000_0001);
		if (o == core_decode_pkg::OPC_TJZ) t = !t;
		return t ? core_decode_pkg::PLAIN_CLKS : core_decode_pkg::BRANCH_SLOW_CLKS;
	endfunction
	// Load operands, issue, then poll busy until the core is idle
	task automatic run(input logic [31:0] ins, input logic [31:0] dv, input logic [31:0] sv,
		input logic [1:0] fl);
		wr(core_decode_pkg::OFS_INSTR, ins);
		wr(core_decode_pkg::OFS_DVAL, dv);
		wr(core_decode_pkg::OFS_SVAL, sv);
		wr(core_decode_pkg::OFS_FLAGS, {30'h0000_0000, fl});
		issue();
	endtask
	// Start the loaded instruction and wait for idle
	task automatic issue();
		wr(core_decode_pkg::OFS_CTRL, 32'h0000_0001);
		rd = 32'h0000_0001;
		while (rd[0] !== 1'h0) rdw(core_decode_pkg::OFS_STATUS);
	endtask
	initial begin
		void'($urandom(22784));
		op = '{core_decode_pkg::OPC_ADD_ABSOLUTE, core_decode_pkg::OPC_SUBTRACT_ABSOLUTE,
			core_decode_pkg::OPC_UNSIGNED_EXTENDED_SUBTRACT, core_decode_pkg::OPC_SIGNED_EXTENDED_SUBTRACT,
			core_decode_pkg::OPC_DECREMENT_JUMP_NONZERO, core_decode_pkg::OPC_VWAIT, core_decode_pkg::OPC_TEST_JUMP_NONZERO,
			core_decode_pkg::OPC_TJZ, {core_decode_pkg::HUB_OPC_HI, 2'h2}};
		repeat (12) @(posedge clk_in);
		arst_n_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		rdw(core_decode_pkg::OFS_FRAME);
		cmp(rd, {16'h0000, core_decode_pkg::FRAME_RESET});
		rdw(8'h40);
		cmp({rd[29:0], rs}, {30'h0000_0000, core_decode_pkg::RESP_SLVERR});
		$display("test registers done");
		// Random operands, equal operands first for the zero cases
		for (int i = 0; i < 16; i++) begin
			d = $urandom();
			s = (i < 4) ? d : 32'($urandom());
			x = (i < 4) ? 4'hE : 4'($urandom());
			f = 2'($urandom());
			e = alu(op[i % 4], d, x[0] ? {23'h00_0000, s[8:0]} : s, f);
			run(iw(op[i % 4], x, s[8:0]), d, s, f);
			rdw(core_decode_pkg::OFS_DVAL);
			cmp(rd, x[1] ? e[31:0] : d);
			rdw(core_decode_pkg::OFS_FLAGS);
			cmp(rd, {30'h0000_0000, x[2] ? e[32] : f[1], x[3] ? e[33] : f[0]});
		end
		$display("test arithmetic done");
		// Branches with corner values, then video wait
		for (int i = 0; i < 6; i++) begin
			d = i[0] ? $urandom() : 32'(i < 2);
			o = op[(i < 2) ? 4 : 5 + i / 2];
			run(iw(o, 4'hB, 9'(i)), d, 32'h0000_0000, 2'h0);
			rdw(core_decode_pkg::OFS_CYCLES);
			cmp(rd, {27'h000_0000, brc(o, d)});
		end
		run(iw(op[5], 4'h0, 9'h000), d, d, 2'h0);
		rdw(core_decode_pkg::OFS_CYCLES);
		cmp(rd, {27'h000_0000, core_decode_pkg::VIDEO_WAIT_CLKS});
		// Shared access: first issued on its window, then at random points of the rotation
		for (int i = 0; i < 9; i++) begin
			wr(core_decode_pkg::OFS_INSTR, iw(op[8], 4'h0, 9'h000));
			do @(posedge clk_in); while (i == 0 && win !== 1'h1);
			repeat ((i == 0) ? 13 : $urandom_range(15)) @(posedge clk_in);
			st = 0;
			issue();
			rdw(core_decode_pkg::OFS_CYCLES);
			cmp(rd, 32'(core_decode_pkg::HUB_EXEC_CLKS) + 32'(st));
			cmp(32'(st > core_decode_pkg::HUB_MAX_WAIT || (i == 0 && st != 0)), 32'h0);
		end
		$display("test timing done");
		summarize();
	end
endmodule
